// *** bench/reset_and_watchdog_control_tb.sv ***
`timescale 1ns/1ps
module reset_and_watchdog_control_tb;
	import rst_wdt_pkg::*;
	localparam int TOUT = 8;
	localparam int TICK = 2;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic kick = 1'b0;
	logic ack = 1'b0;
	logic fuse = 1'b1;
	logic pin_en = 1'b1;
	logic [3:0] wen = 4'h0;
	byte_type wd = 8'h00;
	byte_type wdt_rd, mon_rd, flag_rd;
	logic por, pin, below, irst, safe, fetch, wirq, sirq;
	int n_errors = 0;
	int check_count = 0;
	int n;

	// Clock at 20 MHz.
	initial begin
		forever #25 clock = ~clock;
	end

	supply_pin_model supply_pin_model_i (.por_active(por),
		.ext_reset_pin(pin), .supply_below_level(below));

	reset_and_watchdog_control #(.RESET_TIMEOUT_CYCLES(TOUT),
		.TICK_CYCLES(TICK)) reset_and_watchdog_control_i (
		.clock(clock), .resetn(resetn), .por_active(por),
		.ext_reset_pin(pin), .supply_below_level(below),
		.watchdog_always_on_fuse(fuse), .ext_reset_enable(pin_en),
		.watchdog_kick(kick), .wdt_vector_ack(ack),
		.change_protect_key_write(wen[0]), .change_protect_key_wdata(wd),
		.wdt_ctrl_write(wen[1]), .wdt_ctrl_wdata(wd),
		.wdt_ctrl_rdata(wdt_rd), .supply_monitor_ctrl_write(wen[2]),
		.supply_monitor_ctrl_wdata(wd), .supply_monitor_ctrl_rdata(mon_rd),
		.rst_flag_write(wen[3]), .rst_flag_wdata(wd),
		.rst_flag_rdata(flag_rd), .internal_reset(irst),
		.io_safe_state(safe), .fetch_reset_vector(fetch),
		.watchdog_irq(wirq), .supply_low_irq(sirq));

	// Every drive and sample lands 5 ns after the rising edge, save the safe-state sample 1 ns later.
	task automatic cyc(input int k = 1);
		repeat (k) @(posedge clock);
		#5;
	endtask : cyc

	// Strobe k is held across exactly one edge, after a spare cycle.
	task automatic wr(input int k, input byte_type d);
		cyc();
		wen[k] = 1'b1;
		wd = d;
		cyc();
		wen = 4'h0;
	endtask : wr

	// One-cycle core event: 0 is the kick, 1 the vector acknowledge.
	task automatic ev(input int k);
		cyc();
		if (k == 0)
			kick = 1'b1;
		else
			ack = 1'b1;
		cyc();
		kick = 1'b0;
		ack = 1'b0;
	endtask : ev

	task automatic chk(input string what, input byte_type seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Counts cycles until internal reset reaches lvl; a hang ends the run.
	task automatic wait_rst(input logic lvl, input int bound);
		n = 0;
		while (irst !== lvl) begin
			cyc();
			n++;
			if (n > bound) begin
				n_errors++;
				summarize();
			end
		end
	endtask : wait_rst

	task automatic summarize();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	initial begin
		cyc(12);
		resetn = 1'b1;
		cyc(4);
		chk("held in reset", {7'h0, irst}, 8'h01);
		supply_pin_model_i.set_level(0, 1'b0);
		wait_rst(1'b0, 40);
		chk("power-on stretch", {7'h0, n == TOUT + 3}, 8'h01);
		chk("fetch pulse", {7'h0, fetch}, 8'h01);
		chk("power-on flag", {7'h0, flag_rd[0]}, 8'h01);
		// Pin low must reach the port pins with no clock edge.
		supply_pin_model_i.set_level(1, 1'b0);
		#1;
		chk("safe state", {7'h0, safe}, 8'h01);
		cyc(4);
		chk("pin reset", {7'h0, irst}, 8'h01);
		supply_pin_model_i.set_level(1, 1'b1);
		wait_rst(1'b0, 40);
		chk("pin stretch", {7'h0, n == TOUT + 3}, 8'h01);
		chk("pin flag", {7'h0, flag_rd[1]}, 8'h01);
		wr(3, 8'h00);
		chk("flags cleared", flag_rd, 8'h00);
		// Disable is refused without the key, and after the window lapses.
		wr(1, 8'h08);
		chk("enable free", wdt_rd, 8'h08);
		wr(1, 8'h00);
		chk("unkeyed disable", wdt_rd, 8'h08);
		wr(0, CHANGE_PROTECT_SIGNATURE);
		cyc(5);
		wr(1, 8'h00);
		chk("late disable", wdt_rd, 8'h08);
		wr(0, CHANGE_PROTECT_SIGNATURE);
		wr(1, 8'h00);
		chk("keyed disable", wdt_rd, 8'h00);
		// A kick restarts the 2048-tick count.
		wr(1, 8'h08);
		cyc(3000);
		kick = 1'b1;
		cyc();
		kick = 1'b0;
		chk("no early expiry", {7'h0, irst}, 8'h00);
		wait_rst(1'b1, 5000);
		chk("period", {7'h0, n > 4080 && n < 4100}, 8'h01);
		wait_rst(1'b0, 40);
		chk("wd stretch", {7'h0, n == TOUT + 1}, 8'h01);
		chk("wd flag", {7'h0, flag_rd[3]}, 8'h01);
		wr(0, CHANGE_PROTECT_SIGNATURE);
		wr(1, 8'h00);
		chk("enable forced", wdt_rd, 8'h08);
		// Interrupt mode, then combined mode serviced by the vector.
		wr(3, 8'h00);
		wr(1, 8'h40);
		ev(0);
		cyc(4110);
		chk("wd irq", {7'h0, wirq}, 8'h01);
		chk("wd irq flag", wdt_rd, 8'hC0);
		chk("irq mode no reset", {7'h0, irst}, 8'h00);
		wr(1, 8'hC8);
		chk("combined mode", wdt_rd, 8'h48);
		ev(0);
		cyc(4110);
		chk("combined first", wdt_rd, 8'hC8);
		chk("combined no reset", {7'h0, irst}, 8'h00);
		ev(1);
		chk("vector clears", wdt_rd, 8'h08);
		// Interrupt-mode monitor, then reset-mode monitor.
		wr(2, 8'h43);
		supply_pin_model_i.set_level(2, 1'b1);
		cyc(4);
		chk("low flag", mon_rd, 8'hC3);
		chk("low irq", {7'h0, sirq}, 8'h01);
		supply_pin_model_i.set_level(2, 1'b0);
		cyc(4);
		chk("flag recovers", mon_rd, 8'h43);
		wr(2, 8'h01);
		supply_pin_model_i.set_level(2, 1'b1);
		cyc(4);
		chk("monitor reset", {7'h0, irst}, 8'h01);
		// Second power-up with the fuse programmed: safety level two.
		resetn = 1'b0;
		fuse = 1'b0;
		supply_pin_model_i.set_level(2, 1'b0);
		cyc(3);
		resetn = 1'b1;
		wait_rst(1'b0, 40);
		chk("second stretch", {7'h0, n == TOUT + 3}, 8'h01);
		chk("second flag", {7'h0, flag_rd[0]}, 8'h01);
		chk("level two enable", wdt_rd, 8'h08);
		wr(1, 8'h01);
		chk("unkeyed period", wdt_rd, 8'h08);
		wr(0, CHANGE_PROTECT_SIGNATURE);
		wr(1, 8'h01);
		chk("keyed period", wdt_rd, 8'h09);
		// A disabled pin neither resets nor reaches the port pins.
		pin_en = 1'b0;
		supply_pin_model_i.set_level(1, 1'b0);
		cyc(4);
		chk("pin disabled", {7'h0, irst}, 8'h00);
		chk("pin disabled safe", {7'h0, safe}, 8'h00);
		summarize();
	end
endmodule : reset_and_watchdog_control_tb

// *** bench/supply_pin_model.sv ***
`timescale 1ns/1ps
// Far side of the sequencer: supply detectors and the external reset pin.
module supply_pin_model (
	// Detector and pin levels
	output logic por_active,
	output logic ext_reset_pin,
	output logic supply_below_level
);
	// Supply starts below the power-on level; the pin rests high on its pull-up.
	initial begin
		por_active = 1'b1;
		ext_reset_pin = 1'b1;
		supply_below_level = 1'b0;
	end

	// Levels change only when the bench asks, just after a clock edge.
	task automatic set_level(input int k, input logic v);
		case (k)
			0: por_active = v;
			1: ext_reset_pin = v;
			default: supply_below_level = v;
		endcase
	endtask : set_level
endmodule : supply_pin_model

// *** verilog/reset_and_watchdog_control.sv ***
`timescale 1ns/1ps
module reset_and_watchdog_control #(
	parameter int RESET_TIMEOUT_CYCLES = rst_wdt_pkg::RESET_TIMEOUT_CYCLES,
	parameter int TICK_CYCLES = rst_wdt_pkg::WDT_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Reset sources and straps from outside the clock domain
	input wire logic por_active,
	input wire logic ext_reset_pin,
	input wire logic supply_below_level,
	input wire logic watchdog_always_on_fuse,
	// Static configuration
	input wire logic ext_reset_enable,
	// Core events
	input wire logic watchdog_kick,
	input wire logic wdt_vector_ack,
	// Change-protect key write
	input wire logic change_protect_key_write,
	input wire rst_wdt_pkg::byte_type change_protect_key_wdata,
	// Watchdog control byte
	input wire logic wdt_ctrl_write,
	input wire rst_wdt_pkg::byte_type wdt_ctrl_wdata,
	output rst_wdt_pkg::byte_type wdt_ctrl_rdata,
	// Supply monitor control byte
	input wire logic supply_monitor_ctrl_write,
	input wire rst_wdt_pkg::byte_type supply_monitor_ctrl_wdata,
	output rst_wdt_pkg::byte_type supply_monitor_ctrl_rdata,
	// Reset cause flags
	input wire logic rst_flag_write,
	input wire rst_wdt_pkg::byte_type rst_flag_wdata,
	output rst_wdt_pkg::byte_type rst_flag_rdata,
	// Reset and interrupt outputs
	output logic internal_reset,
	output logic io_safe_state,
	output logic fetch_reset_vector,
	output logic watchdog_irq,
	output logic supply_low_irq
);
	import rst_wdt_pkg::*;

	if (RESET_TIMEOUT_CYCLES < 1 || RESET_TIMEOUT_CYCLES > 65535)
	begin : g_bad_timeout
		$error("Reset timeout must fit a 16-bit counter.");
	end

	localparam logic [15:0] TIMEOUT_LOAD = 16'(RESET_TIMEOUT_CYCLES - 1);

	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic por_s, pin_s, below_s, fuse_s;
	logic level_two_reg;
	reset_state_type state_reg;
	logic [15:0] delay_cnt_reg;
	logic por_phase_reg;
	logic hard_src, ext_active, ext_trigger;
	logic por_prev_reg;
	logic [2:0] mon_level_reg;
	logic mon_irq_en_reg, supply_low_flag_reg, below_prev_reg;
	logic mon_below, mon_reset_req, mon_set, mon_clear;
	logic [2:0] win_cnt_reg;
	logic window_open, key_ok;
	logic wd_enable_reg, wd_irq_en_reg, wd_irq_flag_reg;
	logic [3:0] wd_period_reg;
	logic [3:0] wd_period_wr;
	logic eff_enable, irq_mode, wd_run, wd_clear, expire;
	logic wd_fire, wd_flag_set, wd_pulse_reg;
	logic por_flag_reg, ext_flag_reg, wd_cause_reg;

	// Two flip-flops ahead of any logic but io_safe_state for every pin and analog input.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= SYNC_RESET;
			sync_reg <= SYNC_RESET;
		end else begin
			meta_reg <= {watchdog_always_on_fuse, supply_below_level,
				ext_reset_pin, por_active};
			sync_reg <= meta_reg;
		end
	end
	assign por_s = sync_reg[SYNC_POR];
	assign pin_s = sync_reg[SYNC_PIN];
	assign below_s = sync_reg[SYNC_BELOW];
	assign fuse_s = sync_reg[SYNC_FUSE];

	// Fuse is a strap: it is sampled only while the core sits in reset.
	// A programmed fuse (low) selects safety level two.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			level_two_reg <= 1'b0;
		else if (internal_reset)
			level_two_reg <= !fuse_s;
	end

	// Reset source decode; the pin counts only when enabled.
	assign ext_active = ext_reset_enable && !pin_s;
	assign hard_src = por_s || mon_reset_req;
	assign ext_trigger = ext_active && !hard_src &&
		((state_reg == ST_RUN) ||
		(state_reg == ST_DELAY && !por_phase_reg));

	// Reset sequencer: hold while a source is active, then stretch.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_HOLD;
			delay_cnt_reg <= TIMEOUT_LOAD;
			por_phase_reg <= 1'b1;
			fetch_reset_vector <= 1'b0;
		end else begin
			fetch_reset_vector <= 1'b0;
			case (state_reg)
				ST_HOLD: begin
					if (hard_src)
						por_phase_reg <= 1'b1;
					// Delay begins only after every source is gone.
					if (!hard_src && !ext_active) begin
						state_reg <= ST_DELAY;
						delay_cnt_reg <= TIMEOUT_LOAD;
					end
				end
				ST_DELAY: begin
					if (hard_src) begin
						state_reg <= ST_HOLD;
						por_phase_reg <= 1'b1;
					end else if (ext_trigger) begin
						state_reg <= ST_HOLD;
					end else if (delay_cnt_reg == 16'h0000) begin
						por_phase_reg <= 1'b0;
						// Pin checked once, at the end of the power-on count.
						if (por_phase_reg && ext_active) begin
							state_reg <= ST_HOLD;
						end else begin
							state_reg <= ST_RUN;
							fetch_reset_vector <= 1'b1;
						end
					end else begin
						delay_cnt_reg <= delay_cnt_reg - 1'b1;
					end
				end
				ST_RUN: begin
					if (hard_src) begin
						state_reg <= ST_HOLD;
						por_phase_reg <= 1'b1;
					end else if (ext_trigger) begin
						state_reg <= ST_HOLD;
					end else if (wd_pulse_reg) begin
						// Count starts on the falling edge of the pulse.
						state_reg <= ST_DELAY;
						delay_cnt_reg <= TIMEOUT_LOAD;
					end
				end
				default: begin
					state_reg <= ST_HOLD;
				end
			endcase
		end
	end

	// Core reset includes the single watchdog pulse cycle.
	assign internal_reset = (state_reg != ST_RUN) || wd_pulse_reg;
	// Port pins need no clock to reach their safe state, so the raw
	// sources are gated straight through here.
	assign io_safe_state = por_active || internal_reset ||
		(ext_reset_enable && !ext_reset_pin);

	// Supply monitor decode; level zero turns the monitor off.
	assign mon_below = (mon_level_reg != MON_LEVEL_OFF) && below_s;
	assign mon_reset_req = mon_below &&
		(mon_level_reg <= MON_RESET_LEVEL_MAX);
	assign mon_set = mon_below && !below_prev_reg;
	assign mon_clear = !mon_below || (supply_monitor_ctrl_write &&
		(!supply_monitor_ctrl_wdata[MON_FLAG_BIT] ||
		supply_monitor_ctrl_wdata[MON_LEVEL_MSB:0] != mon_level_reg));

	// Monitor setup survives the core reset it may itself cause;
	// only power-on clears it, else reset mode could never hold.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mon_level_reg <= MON_LEVEL_OFF;
			mon_irq_en_reg <= 1'b0;
		end else if (por_s) begin
			mon_level_reg <= MON_LEVEL_OFF;
			mon_irq_en_reg <= 1'b0;
		end else if (supply_monitor_ctrl_write) begin
			mon_level_reg <= supply_monitor_ctrl_wdata[MON_LEVEL_MSB:0];
			mon_irq_en_reg <= supply_monitor_ctrl_wdata[MON_IRQ_EN_BIT];
		end
	end

	// Supply-low flag: a new fall wins over any clear.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			supply_low_flag_reg <= 1'b0;
			below_prev_reg <= 1'b0;
		end else begin
			below_prev_reg <= mon_below;
			if (mon_set)
				supply_low_flag_reg <= 1'b1;
			else if (mon_clear)
				supply_low_flag_reg <= 1'b0;
		end
	end
	assign supply_low_irq = supply_low_flag_reg && mon_irq_en_reg;

	// Protected-change window, four cycles or one write.
	assign key_ok = change_protect_key_write &&
		change_protect_key_wdata == CHANGE_PROTECT_SIGNATURE;
	assign window_open = win_cnt_reg != 3'h0;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			win_cnt_reg <= 3'h0;
		else if (internal_reset)
			win_cnt_reg <= 3'h0;
		else if (key_ok)
			win_cnt_reg <= PROTECT_WINDOW_CYCLES;
		else if (wdt_ctrl_write && window_open)
			win_cnt_reg <= 3'h0;
		else if (window_open)
			win_cnt_reg <= win_cnt_reg - 1'b1;
	end

	// Mode decode; the cause flag and level two pin the reset enable.
	assign eff_enable = wd_enable_reg || wd_cause_reg || level_two_reg;
	assign irq_mode = wd_irq_en_reg && !level_two_reg;
	assign wd_run = eff_enable || irq_mode;
	assign wd_clear = watchdog_kick || internal_reset;
	assign wd_period_wr = {wdt_ctrl_wdata[WDT_PERIOD_HI_BIT],
		wdt_ctrl_wdata[WDT_PERIOD_LO_MSB:0]};

	watchdog_counter #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_counter (
		.clock(clock),
		.resetn(resetn),
		.run(wd_run),
		.clear(wd_clear),
		.period_select(wd_period_reg),
		.expire(expire)
	);

	// Combined mode interrupts first and resets on the next expiry
	// if the flag was never serviced.
	assign wd_fire = expire && !internal_reset && eff_enable &&
		(!irq_mode || wd_irq_flag_reg);
	assign wd_flag_set = expire && !internal_reset && irq_mode &&
		!(eff_enable && wd_irq_flag_reg);

	// Watchdog configuration writes.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wd_enable_reg <= 1'b0;
			wd_irq_en_reg <= 1'b0;
			wd_period_reg <= 4'h0;
		end else if (internal_reset) begin
			wd_enable_reg <= 1'b0;
			wd_irq_en_reg <= 1'b0;
			wd_period_reg <= 4'h0;
		end else if (wdt_ctrl_write) begin
			wd_irq_en_reg <= wdt_ctrl_wdata[WDT_IRQ_EN_BIT];
			if (!level_two_reg) begin
				wd_period_reg <= wd_period_wr;
				// Setting is free; clearing needs the open window.
				if (wdt_ctrl_wdata[WDT_ENABLE_BIT])
					wd_enable_reg <= 1'b1;
				else if (window_open)
					wd_enable_reg <= 1'b0;
			end else if (window_open) begin
				wd_period_reg <= wd_period_wr;
			end
		end else if (wdt_vector_ack && eff_enable) begin
			wd_irq_en_reg <= 1'b0;
		end
	end

	// Interrupt flag: expiry wins over vector and write-one clears.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			wd_irq_flag_reg <= 1'b0;
		else if (wd_flag_set)
			wd_irq_flag_reg <= 1'b1;
		else if (internal_reset || wdt_vector_ack)
			wd_irq_flag_reg <= 1'b0;
		else if (wdt_ctrl_write && wdt_ctrl_wdata[WDT_IRQ_FLAG_BIT])
			wd_irq_flag_reg <= 1'b0;
	end
	assign watchdog_irq = wd_irq_flag_reg && wd_irq_en_reg;

	// Reset pulse from the watchdog, exactly one cycle.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			wd_pulse_reg <= 1'b0;
		else
			wd_pulse_reg <= wd_fire && !wd_pulse_reg;
	end

	// Reset cause flags; hardware set wins over a software zero.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			por_prev_reg <= 1'b1;
			por_flag_reg <= 1'b0;
			ext_flag_reg <= 1'b0;
			wd_cause_reg <= 1'b0;
		end else begin
			por_prev_reg <= por_s;
			if (por_prev_reg && !por_s)
				por_flag_reg <= 1'b1;
			else if (rst_flag_write && !rst_flag_wdata[POR_FLAG_BIT])
				por_flag_reg <= 1'b0;
			if (ext_trigger)
				ext_flag_reg <= 1'b1;
			else if (rst_flag_write && !rst_flag_wdata[EXT_FLAG_BIT])
				ext_flag_reg <= 1'b0;
			if (wd_pulse_reg)
				wd_cause_reg <= 1'b1;
			else if (rst_flag_write && !rst_flag_wdata[WDT_FLAG_BIT])
				wd_cause_reg <= 1'b0;
		end
	end

	// Read images; reserved bits read zero.
	assign wdt_ctrl_rdata = {wd_irq_flag_reg, wd_irq_en_reg,
		wd_period_reg[3], 1'b0, eff_enable, wd_period_reg[2:0]};
	assign supply_monitor_ctrl_rdata = {supply_low_flag_reg,
		mon_irq_en_reg, 3'h0, mon_level_reg};
	assign rst_flag_rdata = {4'h0, wd_cause_reg, 1'b0, ext_flag_reg,
		por_flag_reg};

	// Checks on the sequencer, supply monitor and watchdog.
	property p_por_holds;
		@(posedge clock) disable iff (!resetn)
		por_s |=> state_reg == ST_HOLD;
	endproperty
	a_por_holds: assert property (p_por_holds)
		else $error("Power-on source did not force hold.");

	property p_release_after_count;
		@(posedge clock) disable iff (!resetn)
		$rose(state_reg == ST_RUN) |->
			$past(state_reg) == ST_DELAY && $past(delay_cnt_reg) == 16'h0000
			&& fetch_reset_vector;
	endproperty
	a_release_after_count: assert property (p_release_after_count)
		else $error("Release without a completed delay count.");

	property p_wd_pulse;
		@(posedge clock) disable iff (!resetn)
		wd_pulse_reg |=> !wd_pulse_reg && state_reg == ST_DELAY &&
			delay_cnt_reg == TIMEOUT_LOAD && wd_cause_reg;
	endproperty
	a_wd_pulse: assert property (p_wd_pulse)
		else $error("Watchdog pulse not one cycle or delay not started.");

	property p_pin_ignored;
		@(posedge clock) disable iff (!resetn)
		(state_reg == ST_DELAY && por_phase_reg && !hard_src &&
			delay_cnt_reg != 16'h0000) |=> state_reg == ST_DELAY;
	endproperty
	a_pin_ignored: assert property (p_pin_ignored)
		else $error("Reset pin acted during power-on count.");

	property p_flag_clears;
		@(posedge clock) disable iff (!resetn)
		!mon_below |=> !supply_low_flag_reg;
	endproperty
	a_flag_clears: assert property (p_flag_clears)
		else $error("Supply-low flag stayed set above level.");

	property p_enable_forced;
		@(posedge clock) disable iff (!resetn)
		(wd_cause_reg || level_two_reg) |-> wdt_ctrl_rdata[WDT_ENABLE_BIT];
	endproperty
	a_enable_forced: assert property (p_enable_forced)
		else $error("Watchdog enable read zero while forced.");

	property p_no_free_disable;
		@(posedge clock) disable iff (!resetn)
		(wdt_ctrl_write && !window_open && wd_enable_reg &&
			!internal_reset) |=> wd_enable_reg;
	endproperty
	a_no_free_disable: assert property (p_no_free_disable)
		else $error("Watchdog disabled without protected window.");

	property p_window_closes;
		@(posedge clock) disable iff (!resetn)
		key_ok && !internal_reset ##1 !key_ok [*4] |=> !window_open;
	endproperty
	a_window_closes: assert property (p_window_closes)
		else $error("Protect window open beyond four cycles.");

	property p_vector_clears;
		@(posedge clock) disable iff (!resetn)
		(wdt_vector_ack && eff_enable && !wdt_ctrl_write && !wd_flag_set)
			|=> !wd_irq_en_reg && !wd_irq_flag_reg;
	endproperty
	a_vector_clears: assert property (p_vector_clears)
		else $error("Vector did not clear watchdog interrupt state.");

	c_wd_reset: cover property (@(posedge clock) disable iff (!resetn)
		wd_pulse_reg);
	c_release: cover property (@(posedge clock) disable iff (!resetn)
		fetch_reset_vector);
	c_supply_irq: cover property (@(posedge clock) disable iff (!resetn)
		supply_low_irq);
	c_pin_extend: cover property (@(posedge clock) disable iff (!resetn)
		state_reg == ST_DELAY && por_phase_reg && ext_active &&
		delay_cnt_reg == 16'h0000);

endmodule : reset_and_watchdog_control

// *** verilog/rst_wdt_pkg.sv ***
// Contract
// - Hold every register at its initial value in reset; fetch reset vector on release.
// - Port pins go to safe state combinationally once any reset source is active; the supply monitor reaches them only via internal_reset.
// - After all sources release, internal reset stays until the delay count ends.
// - Reset sources are power-on detector, supply monitor in reset mode, low reset pin, and watchdog expiry.
// - Power-on release starts the delay counter before internal reset drops.
// - Supply falling below the power-on level reasserts reset at once, no delay.
// - Supply-low flag set while below level; interrupt when its enable is set.
// - Supply-low flag clears on level change, written zero, or supply recovery.
// - Monitor in reset mode holds reset while low, then runs power-up start-up.
// - Power-on reset flag is set once the supply has recovered.
// - Enabled reset pin low causes reset; short pulses need not.
// - Reset pin rising starts the delay count; release after the timeout.
// - Pin ignored during power-on count; extends reset only if low at its end.
// - Watchdog expiry gives a one-cycle reset pulse; delay starts after it.
// - Watchdog counter ticks at 128 kHz, independent of the system clock; the code divides the system clock by WDT_TICK_CYCLES instead.
// - Watchdog counter clears on kick, when disabled, and on any reset.
// - Ten selectable watchdog periods counted in watchdog oscillator cycles.
// - Watchdog expiry may raise an interrupt instead of a reset.
// - Always-on fuse selects safety level one or two.
// - Level one: enable freely; disable needs signature then write within four cycles.
// - Level two: enable reads one; period change needs signature window.
// - Watchdog reset flag forces the reset enable to one.
// - Periods double from 2048 to 1048576 cycles; other codes reserved.
// - Interrupt vector in combined mode clears interrupt enable and flag.
package rst_wdt_pkg;

	typedef logic [7:0] byte_type;
	typedef enum {ST_HOLD, ST_DELAY, ST_RUN} reset_state_type;

	// Clock and watchdog oscillator rates.
	localparam int CLK_HZ = 20_000_000;
	localparam int WDT_OSC_HZ = 128_000;
	localparam int WDT_TICK_CYCLES = CLK_HZ / WDT_OSC_HZ;

	// Reset stretch time.
	localparam int RESET_TIMEOUT_US = 64;
	localparam int RESET_TIMEOUT_CYCLES =
		RESET_TIMEOUT_US * (CLK_HZ / 1_000_000);

	// Protected change sequence.
	localparam byte_type CHANGE_PROTECT_SIGNATURE = 8'hD8;
	localparam logic [2:0] PROTECT_WINDOW_CYCLES = 3'h4;

	// Watchdog control byte layout.
	localparam int WDT_IRQ_FLAG_BIT = 7;
	localparam int WDT_IRQ_EN_BIT = 6;
	localparam int WDT_PERIOD_HI_BIT = 5;
	localparam int WDT_ENABLE_BIT = 3;
	localparam int WDT_PERIOD_LO_MSB = 2;

	// Watchdog periods.
	localparam int WDT_COUNT_W = 21;
	localparam int WDT_PERIOD_MIN_LOG2 = 11;
	localparam logic [3:0] WDT_PERIOD_MAX_CODE = 4'h9;

	// Supply monitor control byte layout.
	localparam int MON_FLAG_BIT = 7;
	localparam int MON_IRQ_EN_BIT = 6;
	localparam int MON_LEVEL_MSB = 2;
	localparam logic [2:0] MON_LEVEL_OFF = 3'h0;
	localparam logic [2:0] MON_RESET_LEVEL_MAX = 3'h2;

	// Reset cause flags layout.
	localparam int POR_FLAG_BIT = 0;
	localparam int EXT_FLAG_BIT = 1;
	localparam int WDT_FLAG_BIT = 3;

	// Synchroniser order and reset image: por, pin, below, fuse.
	localparam int SYNC_POR = 0;
	localparam int SYNC_PIN = 1;
	localparam int SYNC_BELOW = 2;
	localparam int SYNC_FUSE = 3;
	localparam logic [3:0] SYNC_RESET = 4'hB;

	// Period select to cycle count; reserved codes act as the longest.
	function automatic logic [WDT_COUNT_W-1:0] wdt_period_cycles(
		input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > WDT_PERIOD_MAX_CODE) ? WDT_PERIOD_MAX_CODE : sel;
		return WDT_COUNT_W'(1) << (WDT_PERIOD_MIN_LOG2 + int'(s));
	endfunction : wdt_period_cycles

endpackage : rst_wdt_pkg

// *** verilog/watchdog_counter.sv ***
`timescale 1ns/1ps
module watchdog_counter #(
	parameter int TICK_CYCLES = rst_wdt_pkg::WDT_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Control
	input wire logic run,
	input wire logic clear,
	input wire logic [3:0] period_select,
	// Expiry pulse
	output logic expire
);
	import rst_wdt_pkg::*;

	localparam int DIV_W = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("Watchdog tick divider must be at least two.");
	end

	logic [DIV_W-1:0] div_reg;
	logic tick;
	logic [WDT_COUNT_W-1:0] count_reg;
	logic [WDT_COUNT_W-1:0] limit;
	logic at_limit;

	// The divider stands in for the separate oscillator; it never stops,
	// so the watchdog keeps time whatever the core is doing.
	assign tick = div_reg == DIV_W'(TICK_CYCLES - 1);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			div_reg <= '0;
		else if (tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end

	// Period length in oscillator cycles.
	assign limit = wdt_period_cycles(period_select);
	assign at_limit = count_reg == limit - 1'b1;

	// Counter clears on kick, disable or reset.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			count_reg <= '0;
		else if (clear || !run)
			count_reg <= '0;
		else if (tick)
			count_reg <= at_limit ? '0 : count_reg + 1'b1;
	end

	// One-cycle expiry pulse.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			expire <= 1'b0;
		else
			expire <= run && !clear && tick && at_limit;
	end

endmodule : watchdog_counter
